/* core/frc_regs.svh */
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH

// Clock rate in kHz, used to derive every cycle count from its time.
`define FRC_CLK_KHZ          125000
// Overcurrent deglitch, in milliseconds.
`define FRC_OC_DGL_MS        9
`define FRC_OC_DGL_CYC       (`FRC_OC_DGL_MS * `FRC_CLK_KHZ)
// Overtemperature release delay, in milliseconds.
`define FRC_OT_REL_MS        9
`define FRC_OT_REL_CYC       (`FRC_OT_REL_MS * `FRC_CLK_KHZ)
// Attach window, in seconds.
`define FRC_ATTACH_S         25
`define FRC_ATTACH_CYC       (64'd`FRC_ATTACH_S * 64'd1000 * `FRC_CLK_KHZ)

// APB byte offsets.
`define FRC_CTRL_OFS         12'h000
`define FRC_STATUS_OFS       12'h004
`define FRC_IRQ_STAT_OFS     12'h008
`define FRC_IRQ_EN_OFS       12'h00C
`define FRC_IRQ_CLR_OFS      12'h010

// Control register fields.
`define FRC_CTRL_ENABLE      0
`define FRC_CTRL_PLUGW       1
`define FRC_CTRL_PROF_LSB    2
`define FRC_CTRL_RESET       32'h0000_0000
`define FRC_PROF_DISCH       3'h0

// Interrupt bits.
`define FRC_IRQ_ALERT        0
`define FRC_IRQ_ATTACH       1
`define FRC_IRQ_OT           2
`define FRC_IRQ_W            3

`endif

/* core/frc_pkg.sv */
package frc_pkg;

  typedef enum logic [3:0] {
    FRC_OFF  = 4'h1,
    FRC_RUN  = 4'h2,
    FRC_HOT  = 4'h4,
    FRC_COOL = 4'h8
  } frc_mode_e;

  typedef struct packed {
    logic       overCurrent;
    logic       overTemp;
    logic       attachSeen;
  } frc_sense_s;

  typedef struct packed {
    logic       powerSwitchOn;
    logic       dataSwitchOn;
    logic       profilesOn;
    logic       dischargeOn;
    logic       attachDetectOn;
  } frc_drive_s;

  typedef struct packed {
    logic       enable;
    logic       plugWatch;
    logic [2:0] profileSelect;
  } frc_ctrl_s;

  typedef struct packed {
    frc_mode_e  mode;
    frc_ctrl_s  ctrl;
    logic [31:0] ocCount;
    logic [31:0] otCount;
    logic [31:0] attCount;
    logic        alert;
    logic        chgPlug;
    logic        attachPrev;
    logic [2:0]  irqStat;
    logic [2:0]  irqEn;
    logic [31:0] prdata;
  } frc_state_s;

endpackage

/* core/fault_report_and_enable_control.sv */
`timescale 1ns/10ps
`include "frc_regs.svh"

// Summary of operation
// - The alert pin is driven low while an overload lasts, then released.
// - An overcurrent raises the alert only after a 9 ms deglitch time.
// - An overtemperature raises the alert at once, with no filtering.
// - After overtemperature the alert is released a delay after cool-down.
// - Enable is active high; low enable puts the block in its off state.
// - With enable low the power, data and profile switches are all off.
// - With enable low the alert flag is released; charge-or-plug is too unless an attachment set it.
// - With enable low and plug watch clear the discharge path is on.
// - Enable low with plug watch set detects attachments, no discharge.
// - A new attachment pulls the charge-or-plug flag low for 25 s.
// - Enable high, plug watch clear and profile select 000 discharge too.
module fault_report_and_enable_control (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output      logic [31:0]        prdata,
  output      logic               pready,
  output      logic               pslverr,
  input  wire frc_pkg::frc_sense_s sense,
  output      frc_pkg::frc_drive_s drive,
  output      logic               alertOut,
  output      logic               alertOe_b,
  output      logic               chgPlugOut,
  output      logic               chgPlugOe_b,
  output      logic               irq
);

  localparam logic [31:0] OcDglCyc  = 32'(`FRC_OC_DGL_CYC);
  localparam logic [31:0] OtRelCyc  = 32'(`FRC_OT_REL_CYC);
  localparam logic [31:0] AttachCyc = 32'(`FRC_ATTACH_CYC);

  frc_pkg::frc_state_s st;
  frc_pkg::frc_state_s next_st;

  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic addrOk;
  logic enabled;
  logic attachMode;
  logic attachEdge;
  logic [2:0] events;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign apbAccess = psel && penable;
  assign apbWrite  = apbAccess && pwrite;
  assign apbRead   = apbAccess && !pwrite;
  assign addrOk    = (paddr == `FRC_CTRL_OFS) || (paddr == `FRC_STATUS_OFS)
                  || (paddr == `FRC_IRQ_STAT_OFS)
                  || (paddr == `FRC_IRQ_EN_OFS)
                  || (paddr == `FRC_IRQ_CLR_OFS);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess && !addrOk;
  assign prdata    = st.prdata;

  assign enabled    = st.ctrl.enable;
  assign attachMode = !enabled && st.ctrl.plugWatch;
  // Only attachments made after detection is armed count, so the edge
  // detector is primed while detection is off.
  assign attachEdge = attachMode && sense.attachSeen && !st.attachPrev;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    events  = 3'h0;
    next_st.attachPrev = sense.attachSeen;
    if (apbWrite && paddr == `FRC_CTRL_OFS) begin
      next_st.ctrl.enable        = pwdata[`FRC_CTRL_ENABLE];
      next_st.ctrl.plugWatch     = pwdata[`FRC_CTRL_PLUGW];
      next_st.ctrl.profileSelect = pwdata[`FRC_CTRL_PROF_LSB +: 3];
    end
    if (apbWrite && paddr == `FRC_IRQ_EN_OFS) begin
      next_st.irqEn = pwdata[2:0];
    end

    case (st.mode)
      frc_pkg::FRC_OFF: begin
        next_st.alert   = 1'b0;
        next_st.ocCount = 32'h0;
        next_st.otCount = 32'h0;
        if (enabled) begin
          next_st.mode    = frc_pkg::FRC_RUN;
          next_st.chgPlug = 1'b0;
        end
      end
      frc_pkg::FRC_RUN: begin
        if (sense.overTemp) begin
          next_st.alert = 1'b1;
          next_st.mode  = frc_pkg::FRC_HOT;
          next_st.ocCount = 32'h0;
          events[`FRC_IRQ_OT] = 1'b1;
        end else if (sense.overCurrent) begin
          if (st.ocCount >= OcDglCyc - 32'h1) begin
            next_st.alert = 1'b1;
          end else begin
            next_st.ocCount = st.ocCount + 32'h1;
          end
        end else begin
          next_st.ocCount = 32'h0;
          next_st.alert   = 1'b0;
        end
      end
      frc_pkg::FRC_HOT: begin
        next_st.alert = 1'b1;
        if (!sense.overTemp) begin
          next_st.mode    = frc_pkg::FRC_COOL;
          next_st.otCount = 32'h0;
        end
      end
      frc_pkg::FRC_COOL: begin
        if (sense.overTemp) begin
          next_st.mode = frc_pkg::FRC_HOT;
        end else if (st.otCount >= OtRelCyc - 32'h1) begin
          next_st.mode    = frc_pkg::FRC_RUN;
          next_st.alert   = sense.overCurrent;
          next_st.ocCount = 32'h0;
        end else begin
          next_st.otCount = st.otCount + 32'h1;
        end
      end
      default: begin
        next_st.mode = frc_pkg::FRC_OFF;
      end
    endcase

    if (!enabled) begin
      next_st.mode  = frc_pkg::FRC_OFF;
      next_st.alert = 1'b0;
      if (attachEdge) begin
        next_st.chgPlug  = 1'b1;
        next_st.attCount = 32'h0;
        events[`FRC_IRQ_ATTACH] = 1'b1;
      end else if (st.chgPlug && st.attCount < AttachCyc - 32'h1) begin
        next_st.attCount = st.attCount + 32'h1;
      end else begin
        next_st.chgPlug = 1'b0;
      end
      if (!st.ctrl.plugWatch) begin
        next_st.chgPlug = 1'b0;
      end
    end
    events[`FRC_IRQ_ALERT] = next_st.alert && !st.alert;

    // Set wins over clear so an event in the clearing cycle survives.
    if (apbWrite && paddr == `FRC_IRQ_CLR_OFS) begin
      next_st.irqStat = st.irqStat & ~pwdata[2:0];
    end
    next_st.irqStat = next_st.irqStat | events;

    next_st.prdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `FRC_CTRL_OFS: begin
          next_st.prdata = {27'h0, st.ctrl.profileSelect,
                            st.ctrl.plugWatch, st.ctrl.enable};
        end
        `FRC_STATUS_OFS: begin
          next_st.prdata = {24'h0, st.mode, 1'b0, attachMode,
                            st.chgPlug, st.alert};
        end
        `FRC_IRQ_STAT_OFS: begin
          next_st.prdata = {29'h0, st.irqStat};
        end
        `FRC_IRQ_EN_OFS: begin
          next_st.prdata = {29'h0, st.irqEn};
        end
        default: begin
          next_st.prdata = 32'h0;
        end
      endcase
    end else if (apbRead) begin
      next_st.prdata = st.prdata;
    end

    if (!rst_b) begin
      next_st.mode       = frc_pkg::FRC_OFF;
      next_st.ctrl       = frc_pkg::frc_ctrl_s'(5'(`FRC_CTRL_RESET));
      next_st.ocCount    = 32'h0;
      next_st.otCount    = 32'h0;
      next_st.attCount   = 32'h0;
      next_st.alert      = 1'b0;
      next_st.chgPlug    = 1'b0;
      next_st.attachPrev = 1'b1;
      next_st.irqStat    = 3'h0;
      next_st.irqEn      = 3'h0;
      next_st.prdata     = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb begin
    drive.powerSwitchOn  = enabled && st.mode == frc_pkg::FRC_RUN;
    drive.dataSwitchOn   = enabled;
    drive.profilesOn     = enabled;
    drive.attachDetectOn = attachMode;
    drive.dischargeOn    = !st.ctrl.plugWatch && (!enabled ||
                           st.ctrl.profileSelect == `FRC_PROF_DISCH);
  end

  // Open-drain pins: only ever drive low, enable low means driving.
  assign alertOut    = 1'b0;
  assign alertOe_b   = !st.alert;
  assign chgPlugOut  = 1'b0;
  assign chgPlugOe_b = !st.chgPlug;
  assign irq         = |(st.irqStat & st.irqEn);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_DIS_FLAGS: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable |=> !st.alert)
    else $error("Alert stayed set while disabled.");
  AST_OT_FAST: assert property (@(posedge clk) disable iff (!rst_b)
    st.ctrl.enable && sense.overTemp && $past(st.ctrl.enable)
      |=> st.alert || !st.ctrl.enable)
    else $error("Overtemperature alert was late.");
  AST_OC_NOEARLY: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_RUN && !st.alert && st.ocCount < OcDglCyc - 32'h1
      |=> !st.alert || $past(sense.overTemp))
    else $error("Overcurrent alert before deglitch end.");
  AST_OC_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_RUN && !sense.overCurrent |=> st.ocCount == 32'h0)
    else $error("Deglitch count not restarted.");
  AST_SW_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable |-> !drive.powerSwitchOn && !drive.profilesOn
      && !drive.dataSwitchOn)
    else $error("Switch on while disabled.");
  AST_DISCH: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable && !st.ctrl.plugWatch |-> drive.dischargeOn)
    else $error("Discharge off while disabled.");
  AST_ATTACH_MODE: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable && st.ctrl.plugWatch
      |-> drive.attachDetectOn && !drive.dischargeOn)
    else $error("Attach mode not entered.");
  AST_ATTACH_SET: assert property (@(posedge clk) disable iff (!rst_b)
    attachEdge && $stable(st.ctrl) |=> st.chgPlug ##1 (st.chgPlug
      || $past(st.ctrl.enable) || !$past(st.ctrl.plugWatch)))
    else $error("Attach flag not held.");
  AST_COOL_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_COOL |-> st.alert)
    else $error("Alert dropped before cool-down delay.");
  AST_OC_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_RUN && !sense.overCurrent && !sense.overTemp
      && st.ctrl.enable && $past(st.ctrl.enable) |=> !st.alert)
    else $error("Alert not released.");

  // ------------------------------------------------------------------
  // Fault timing checks
  // ------------------------------------------------------------------
  AST_HOT_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_RUN && sense.overTemp && st.ctrl.enable
      |=> st.mode == frc_pkg::FRC_HOT && st.alert)
    else $error("Overtemperature did not enter the hot state.");
  AST_HOT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_HOT |-> st.alert)
    else $error("Alert dropped while hot.");
  AST_COOL_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_HOT && !sense.overTemp && st.ctrl.enable
      |=> st.mode == frc_pkg::FRC_COOL && st.otCount == 32'h0)
    else $error("Cool-down delay not started.");
  AST_COOL_RETURN: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_COOL && sense.overTemp && st.ctrl.enable
      |=> st.mode == frc_pkg::FRC_HOT)
    else $error("Renewed overtemperature not seen.");
  AST_COOL_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_COOL && !sense.overTemp && st.ctrl.enable
      && st.otCount < OtRelCyc - 32'h1
      |=> st.otCount == $past(st.otCount) + 32'h1)
    else $error("Cool-down count did not advance.");
  AST_COOL_END: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_COOL && !sense.overTemp && st.ctrl.enable
      && st.otCount >= OtRelCyc - 32'h1
      |=> st.mode == frc_pkg::FRC_RUN && st.alert == $past(sense.overCurrent))
    else $error("Cool-down delay did not end.");
  AST_OC_ALERT: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_RUN && sense.overCurrent && !sense.overTemp
      && st.ctrl.enable && st.ocCount >= OcDglCyc - 32'h1
      |=> st.alert)
    else $error("Overcurrent alert missing after deglitch.");
  AST_OC_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_RUN && sense.overCurrent && !sense.overTemp
      && st.ctrl.enable && st.ocCount < OcDglCyc - 32'h1
      |=> st.ocCount == $past(st.ocCount) + 32'h1)
    else $error("Deglitch count did not advance.");

  // ------------------------------------------------------------------
  // Enable, discharge and attach checks
  // ------------------------------------------------------------------
  AST_OFF_MODE: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable |=> st.mode == frc_pkg::FRC_OFF)
    else $error("Block not off while disabled.");
  AST_RUN_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
    st.mode == frc_pkg::FRC_OFF && st.ctrl.enable
      |=> st.mode == frc_pkg::FRC_RUN)
    else $error("Block did not start when enabled.");
  AST_DISCH_RUN: assert property (@(posedge clk) disable iff (!rst_b)
    st.ctrl.enable && !st.ctrl.plugWatch
      && st.ctrl.profileSelect == `FRC_PROF_DISCH |-> drive.dischargeOn)
    else $error("Discharge off for the discharge profile.");
  AST_DETECT_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    st.ctrl.enable |-> !drive.attachDetectOn)
    else $error("Attach detection on while enabled.");
  AST_DIS_PLUG: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable && !st.ctrl.plugWatch |=> !st.chgPlug)
    else $error("Charge flag set while disabled.");
  AST_NO_FALSE: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable && !st.chgPlug && !attachEdge |=> !st.chgPlug)
    else $error("Charge flag set without an attachment.");
  AST_ATTACH_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable && st.ctrl.plugWatch && st.chgPlug
      && st.attCount < AttachCyc - 32'h1 |=> st.chgPlug)
    else $error("Attach flag dropped inside its window.");
  AST_ATTACH_END: assert property (@(posedge clk) disable iff (!rst_b)
    !st.ctrl.enable && st.chgPlug && !attachEdge
      && st.attCount >= AttachCyc - 32'h1 |=> !st.chgPlug)
    else $error("Attach flag outlived its window.");

  // ------------------------------------------------------------------
  // Bus and interrupt checks
  // ------------------------------------------------------------------
  AST_BAD_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    psel && penable && pwrite && !addrOk
      |=> $stable(st.ctrl) && $stable(st.irqEn))
    else $error("Write to an unmapped address took effect.");
  AST_IRQ_SET: assert property (@(posedge clk) disable iff (!rst_b)
    |events |=> (st.irqStat & $past(events)) == $past(events))
    else $error("Interrupt event was lost.");

endmodule

/* bench/frc_plant_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Sensed conditions and open-drain flag wires
// ----------------------------------------------------------------
// Conditions change only at a clock edge, as the analog comparators
// are already synchronised before they reach the block.
module frc_plant_model (
  input  wire logic          clk,
  input  wire logic          ocReq,
  input  wire logic          otReq,
  input  wire logic          attReq,
  input  wire logic          alertOut,
  input  wire logic          alertOe_b,
  input  wire logic          chgPlugOut,
  input  wire logic          chgPlugOe_b,
  output frc_pkg::frc_sense_s sense,
  output logic               alertPin_b,
  output logic               chgPlugPin_b
);
  initial sense = '0;
  always @(posedge clk) begin
    sense.overCurrent <= ocReq;
    sense.overTemp    <= otReq;
    sense.attachSeen  <= attReq;
  end
  // Both flags have board pull-ups, so a released pin reads high.
  assign alertPin_b   = alertOe_b ? 1'b1 : alertOut;
  assign chgPlugPin_b = chgPlugOe_b ? 1'b1 : chgPlugOut;
endmodule

/* bench/fault_report_and_enable_control_tb_top.sv */
`timescale 1ns/10ps
`include "frc_regs.svh"

module fault_report_and_enable_control_tb_top;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  frc_pkg::frc_sense_s sense;
  frc_pkg::frc_drive_s drive;
  logic                alertOut, alertOe_b, chgPlugOut, chgPlugOe_b, irq;
  logic                ocReq = 1'b0;
  logic                otReq = 1'b0;
  logic                attReq = 1'b0;
  logic                alertPin_b, chgPlugPin_b;
  logic [31:0]         rd;
  logic                err;
  int                  errors = 0;
  int                  checked = 0;
  int                  cycles = 0;

  always #4 clk = ~clk;

  fault_report_and_enable_control u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .drive(drive),
    .alertOut(alertOut), .alertOe_b(alertOe_b), .chgPlugOut(chgPlugOut),
    .chgPlugOe_b(chgPlugOe_b), .irq(irq));

  frc_plant_model u_plant (
    .clk(clk), .ocReq(ocReq), .otReq(otReq), .attReq(attReq),
    .alertOut(alertOut), .alertOe_b(alertOe_b), .chgPlugOut(chgPlugOut),
    .chgPlugOe_b(chgPlugOe_b), .sense(sense), .alertPin_b(alertPin_b),
    .chgPlugPin_b(chgPlugPin_b));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd);
  endtask

  // Samples land one nanosecond after the edge, once its updates settle.
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pins(input logic alertB, input logic plugB);
    chk("alertPin_b", {31'h0, alertB}, {31'h0, alertPin_b});
    chk("chgPlugPin_b", {31'h0, plugB}, {31'h0, chgPlugPin_b});
  endtask

  task automatic end_sim();
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The full deglitch and attach windows exceed the run, so only their
  // early parts are observed here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdChk(`FRC_CTRL_OFS, `FRC_CTRL_RESET);
    rdChk(`FRC_STATUS_OFS, 32'h0000_0010);
    rdChk(`FRC_IRQ_STAT_OFS, 32'h0000_0000);
    rdChk(`FRC_IRQ_EN_OFS, 32'h0000_0000);
    rdChk(`FRC_IRQ_CLR_OFS, 32'h0000_0000);
    rdChk(12'h100, 32'h0000_0000);
    chk("pslverr", 32'h1, {31'h0, err});
    idle(1);
    chk("drive", 32'h0000_0002, {27'h0, drive});
    pins(1'b1, 1'b1);
    wr(32'h0000_0001);
    idle(2);
    chk("dischargeOn", 32'h1, {31'h0, drive.dischargeOn});
    wr(32'h0000_0005);
    idle(2);
    chk("dischargeOn", 32'h0, {31'h0, drive.dischargeOn});
    chk("powerSwitchOn", 32'h1, {31'h0, drive.powerSwitchOn});
    chk("drive", 32'h0000_001C, {27'h0, drive});
    rdChk(`FRC_STATUS_OFS, 32'h0000_0020);
    repeat (2) begin
      ocReq <= 1'b1;
      idle(1000);
      pins(1'b1, 1'b1);
      chk("ocCount", 32'h0000_03E7, u_dut.st.ocCount);
      ocReq <= 1'b0;
      idle(2);
      chk("ocCount", 32'h0000_0000, u_dut.st.ocCount);
    end
    apb(1'b1, `FRC_IRQ_EN_OFS, 32'h0000_0007);
    otReq <= 1'b1;
    idle(3);
    pins(1'b0, 1'b1);
    chk("irq", 32'h1, {31'h0, irq});
    rdChk(`FRC_STATUS_OFS, 32'h0000_0041);
    rdChk(`FRC_IRQ_STAT_OFS, 32'h0000_0005);
    apb(1'b1, `FRC_IRQ_EN_OFS, 32'h0000_0000);
    idle(2);
    chk("irq", 32'h0, {31'h0, irq});
    otReq <= 1'b0;
    idle(1000);
    pins(1'b0, 1'b1);
    rdChk(`FRC_STATUS_OFS, 32'h0000_0081);
    wr(32'h0000_0000);
    idle(2);
    pins(1'b1, 1'b1);
    chk("drive", 32'h0000_0002, {27'h0, drive});
    apb(1'b1, `FRC_IRQ_CLR_OFS, 32'h0000_0007);
    apb(1'b1, `FRC_IRQ_EN_OFS, 32'h0000_0007);
    rdChk(`FRC_IRQ_STAT_OFS, 32'h0000_0000);
    chk("irq", 32'h0, {31'h0, irq});
    attReq <= 1'b1;
    wr(32'h0000_0002);
    idle(4);
    chk("drive", 32'h0000_0001, {27'h0, drive});
    pins(1'b1, 1'b1);
    attReq <= 1'b0;
    idle(2);
    attReq <= 1'b1;
    idle(3);
    pins(1'b1, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    rdChk(`FRC_STATUS_OFS, 32'h0000_0016);
    idle(2000);
    pins(1'b1, 1'b0);
    chk("alertOut", 32'h0, {30'h0, alertOut, chgPlugOut});
    wr(32'h0000_0000);
    idle(2);
    pins(1'b1, 1'b1);
    end_sim();
  end

  task automatic wr(input logic [31:0] d);
    apb(1'b1, `FRC_CTRL_OFS, d);
  endtask
endmodule
